// ===== hw/crs_pkg.sv
package crs_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] CRS_OFF_PC     = 8'h00;
	localparam logic [7:0] CRS_OFF_ACC    = 8'h04;
	localparam logic [7:0] CRS_OFF_TMP    = 8'h08;
	localparam logic [7:0] CRS_OFF_IDX    = 8'h0c;
	localparam logic [7:0] CRS_OFF_EXP    = 8'h10;
	localparam logic [7:0] CRS_OFF_SP     = 8'h14;
	localparam logic [7:0] CRS_OFF_PS     = 8'h18;
	localparam logic [7:0] CRS_OFF_ALU    = 8'h1c;
	localparam logic [7:0] CRS_OFF_IRQ    = 8'h20;
	localparam logic [7:0] CRS_OFF_BANK   = 8'h24;
	localparam logic [7:0] CRS_OFF_ACCESS = 8'h28;
	// reset values
	localparam logic [15:0] CRS_PC_RESET  = 16'hfffd;
	localparam logic [1:0]  CRS_IL_RESET  = 2'h3;
	localparam logic        CRS_IE_RESET  = 1'b0;
	// condition code field positions
	localparam int CRS_CC_H  = 7;
	localparam int CRS_CC_I  = 6;
	localparam int CRS_CC_IL = 4;
	localparam int CRS_CC_N  = 3;
	localparam int CRS_CC_Z  = 2;
	localparam int CRS_CC_V  = 1;
	localparam int CRS_CC_C  = 0;
	// level that forbids every interrupt
	localparam logic [1:0]  CRS_IL_NONE   = 2'h3;
	// memory space: io at the bottom, data above it, program at the top
	localparam logic [15:0] CRS_IO_TOP    = 16'h007f;
	localparam logic [15:0] CRS_DATA_BASE = 16'h0080;
	localparam logic [15:0] CRS_PROG_BASE = 16'h8000;
	// register bank geometry
	localparam logic [15:0] CRS_BANK_BASE = 16'h0100;
	localparam int          CRS_BANK_SHIFT = 3;
	// operations of the flag unit
	typedef enum logic [2:0] {
		CRS_OP_ADD,
		CRS_OP_SUB,
		CRS_OP_SHL,
		CRS_OP_SHR,
		CRS_OP_PASS
	} crs_op_t;
	// area of an address
	typedef enum logic [1:0] {
		CRS_AREA_IO,
		CRS_AREA_DATA,
		CRS_AREA_PROG
	} crs_area_t;
endpackage

// ===== hw/crs_core.sv
`timescale 1ns/100ps
module crs_core #(
	parameter int RAM_BYTES = 256
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             irq_accept,
	output logic      [15:0] bank_address,
	output logic             bank_valid
);
	import crs_pkg::*;

	localparam int BANKS = RAM_BYTES / 16;

	// registers of the core
	logic [15:0] program_counter_reg;
	logic [15:0] accumulator_reg;
	logic [15:0] temp_operand_reg;
	logic [15:0] index_reg_reg;
	logic [15:0] extra_pointer_reg;
	logic [15:0] stack_pointer_reg;
	logic [7:0]  bank_pointer_reg;
	logic        ie_reg;
	logic [1:0]  il_reg;
	logic [4:0]  flags_reg;  // h above n, z, v, c
	// each status bit group has one writer process; this net only assembles them
	wire  [7:0]  condition_code_reg = {flags_reg[4], ie_reg, il_reg, flags_reg[3:0]};
	logic [15:0] alu_ctrl_reg;
	logic [7:0]  result_reg;
	logic [2:0]  irq_level_reg;
	logic [15:0] access_addr_reg;

	// address phase capture
	logic        wr_pend_reg;
	logic [7:0]  addr_reg;

	// area decode of a 16-bit address, used for the access address
	function automatic crs_area_t area_of(input logic [15:0] a);
		if (a <= CRS_IO_TOP)
			return CRS_AREA_IO;
		else if (a < CRS_PROG_BASE)
			return CRS_AREA_DATA;
		else
			return CRS_AREA_PROG;
	endfunction

	// bus decode
	wire         addr_ok    = hsel & hready & htrans[1];
	wire         wr_now     = addr_ok & hwrite;
	wire [31:0]  wd         = hwdata;

	// flag unit: byte operation on low bytes of accumulator and temp operand
	crs_op_t     op;
	// the operation comes from the write data itself, so the flags use the new code
	assign op = crs_op_t'(wd[2:0]);
	wire         alu_go     = wr_pend_reg & (addr_reg == CRS_OFF_ALU);
	wire [7:0]   opa        = accumulator_reg[7:0];
	wire [7:0]   opb        = temp_operand_reg[7:0];
	wire [8:0]   add_full   = {1'b0, opa} + {1'b0, opb};
	wire [8:0]   sub_full   = {1'b0, opa} - {1'b0, opb};
	wire [4:0]   add_lo     = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
	wire [4:0]   sub_lo     = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
	logic [7:0]  res;
	logic        h_out;
	logic        c_out;
	logic        v_out;
	logic        arith;

	// result and flag selection per operation
	always_comb begin
		res   = opa;
		h_out = condition_code_reg[CRS_CC_H];
		c_out = condition_code_reg[CRS_CC_C];
		v_out = condition_code_reg[CRS_CC_V];
		arith = 1'b1;
		case (op)
			CRS_OP_ADD: begin
				res   = add_full[7:0];
				h_out = add_lo[4];
				c_out = add_full[8];
				v_out = (opa[7] == opb[7]) & (res[7] != opa[7]);
			end
			CRS_OP_SUB: begin
				res   = sub_full[7:0];
				h_out = sub_lo[4];
				c_out = sub_full[8];
				v_out = (opa[7] != opb[7]) & (res[7] != opa[7]);
			end
			CRS_OP_SHL: begin
				res   = {opa[6:0], 1'b0};
				c_out = opa[7];
			end
			CRS_OP_SHR: begin
				res   = {1'b0, opa[7:1]};
				c_out = opa[0];
			end
			default: begin
				arith = 1'b0;
			end
		endcase
	end

	// condition code update from the flag unit
	logic [7:0] ccr_alu;
	always_comb begin
		ccr_alu = condition_code_reg;
		if (arith) begin
			ccr_alu[CRS_CC_H] = h_out;
			ccr_alu[CRS_CC_N] = res[7];
			ccr_alu[CRS_CC_Z] = (res == 8'h00);
			ccr_alu[CRS_CC_V] = v_out;
			ccr_alu[CRS_CC_C] = c_out;
		end
	end

	// interrupt acceptance: level 3 never passes, lower code is higher priority
	wire [1:0]   il_cur   = condition_code_reg[CRS_CC_IL +: 2];
	wire         ie_cur   = condition_code_reg[CRS_CC_I];
	wire         req_on   = irq_level_reg[2];
	wire [1:0]   req_lvl  = irq_level_reg[1:0];
	assign irq_accept = ie_cur & req_on
		& (il_cur != CRS_IL_NONE) & (req_lvl < il_cur);

	// bank address: consecutive banks eight bytes apart, limited by ram size
	wire [15:0]  bank_off = {8'h00, bank_pointer_reg} << CRS_BANK_SHIFT;
	assign bank_address = CRS_BANK_BASE + bank_off;
	assign bank_valid   = ({24'h000000, bank_pointer_reg} < BANKS);

	// status word is the bank pointer above the condition codes
	wire [15:0]  ps_word  = {bank_pointer_reg, condition_code_reg};

	// read mux
	wire crs_area_t acc_area = area_of(access_addr_reg);
	logic [31:0] rd_mux;
	always_comb begin
		case (haddr[7:0])
			CRS_OFF_PC:     rd_mux = {16'h0000, program_counter_reg};
			CRS_OFF_ACC:    rd_mux = {16'h0000, accumulator_reg};
			CRS_OFF_TMP:    rd_mux = {16'h0000, temp_operand_reg};
			CRS_OFF_IDX:    rd_mux = {16'h0000, index_reg_reg};
			CRS_OFF_EXP:    rd_mux = {16'h0000, extra_pointer_reg};
			CRS_OFF_SP:     rd_mux = {16'h0000, stack_pointer_reg};
			CRS_OFF_PS:     rd_mux = {16'h0000, ps_word};
			CRS_OFF_ALU:    rd_mux = {16'h0000, result_reg, alu_ctrl_reg[7:0]};
			CRS_OFF_IRQ:    rd_mux = {28'h0000000, irq_accept, irq_level_reg};
			CRS_OFF_BANK:   rd_mux = {15'h0000, bank_valid, bank_address};
			CRS_OFF_ACCESS: rd_mux = {14'h0000, acc_area, access_addr_reg};
			default:        rd_mux = 32'h00000000;
		endcase
	end

	// bus state: every transfer completes with no wait state
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hrdata      <= 32'h00000000;
		end else begin
			wr_pend_reg <= wr_now;
			addr_reg    <= haddr[7:0];
			if (addr_ok & ~hwrite)
				hrdata <= rd_mux;
		end
	end

	// program counter and status control bits carry reset values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			program_counter_reg <= CRS_PC_RESET;
			ie_reg              <= CRS_IE_RESET;
			il_reg              <= CRS_IL_RESET;
		end else if (wr_pend_reg & (addr_reg == CRS_OFF_PC)) begin
			program_counter_reg <= wd[15:0];
		end else if (wr_pend_reg & (addr_reg == CRS_OFF_PS)) begin
			ie_reg <= wd[CRS_CC_I];
			il_reg <= wd[CRS_CC_IL +: 2];
		end
	end

	// data registers have no reset: their contents start undefined
	always_ff @(posedge hclk) begin
		if (wr_pend_reg) begin
			case (addr_reg)
				CRS_OFF_ACC: accumulator_reg   <= wd[15:0];
				CRS_OFF_TMP: temp_operand_reg  <= wd[15:0];
				CRS_OFF_IDX: index_reg_reg     <= wd[15:0];
				CRS_OFF_EXP: extra_pointer_reg <= wd[15:0];
				CRS_OFF_SP:  stack_pointer_reg <= wd[15:0];
				default: begin
				end
			endcase
		end
	end

	// bank pointer and result flags: undefined at reset, written or computed
	always_ff @(posedge hclk) begin
		if (wr_pend_reg & (addr_reg == CRS_OFF_PS)) begin
			bank_pointer_reg <= wd[15:8];
			flags_reg        <= {wd[CRS_CC_H], wd[3:0]};
		end else if (alu_go) begin
			flags_reg <= {ccr_alu[CRS_CC_H], ccr_alu[3:0]};
		end
	end

	// writing the operation register runs the flag unit once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alu_ctrl_reg    <= 16'h0000;
			result_reg      <= 8'h00;
			irq_level_reg   <= 3'h0;
			access_addr_reg <= 16'h0000;
		end else if (wr_pend_reg) begin
			if (addr_reg == CRS_OFF_ALU) begin
				alu_ctrl_reg <= {13'h0000, wd[2:0]};
			end
			if (addr_reg == CRS_OFF_IRQ)
				irq_level_reg <= wd[2:0];
			if (addr_reg == CRS_OFF_ACCESS)
				access_addr_reg <= wd[15:0];
			if (alu_go)
				result_reg <= res;
		end
	end
endmodule

// ===== bench/crs_core_asserts.sv
`timescale 1ns/100ps
module crs_core_asserts import crs_pkg::*; #(
	parameter int RAM_BYTES = 256
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        irq_accept,
	input wire logic [15:0] bank_address,
	input wire logic        bank_valid
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	localparam int BTOP = CRS_BANK_BASE + RAM_BYTES / 2;
	logic       rd_reg;
	logic [7:0] ra_reg;
	wire  [8:0] rq = {rd_reg, ra_reg};
	// note each read address phase; its data stands one edge later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_reg <= 1'b0;
			ra_reg <= 8'h00;
		end else if (hready) begin
			rd_reg <= hsel && htrans[1] && !hwrite;
			ra_reg <= haddr[7:0];
		end
	end
	upper_zero_a: assert property (rd_reg && ra_reg < CRS_OFF_ALU |-> !hrdata[31:16])
		else $error("upper half not zero");
	irq_read_a: assert property (rq == {1'b1, CRS_OFF_IRQ} |-> hrdata[3] == $past(irq_accept))
		else $error("accept bit differs");
	irq_level_a: assert property (rq == {1'b1, CRS_OFF_IRQ} && hrdata[3]
		|-> hrdata[2] && hrdata[1:0] != CRS_IL_NONE) else $error("accept without level");
	bank_read_a: assert property (rq == {1'b1, CRS_OFF_BANK}
		|-> hrdata[16:0] == {$past(bank_valid), $past(bank_address)}) else $error("bank read");
	bank_in_a: assert property (bank_valid |-> bank_address[2:0] == 3'h0
		&& bank_address < BTOP && bank_address >= CRS_BANK_BASE) else $error("bank range");
	bank_out_a: assert property (!bank_valid |-> bank_address >= BTOP)
		else $error("bank wrongly invalid");
	area_read_a: assert property (rq == {1'b1, CRS_OFF_ACCESS} |-> hrdata[17:16] ==
		(hrdata[15:0] <= CRS_IO_TOP ? 2'h0 : hrdata[15:0] >= CRS_PROG_BASE ? 2'h2 : 2'h1))
		else $error("area code");
	nz_excl_a: assert property (rq == {1'b1, CRS_OFF_PS} && hrdata[2] |-> !hrdata[3])
		else $error("zero and negative");
	cover property (rq == {1'b1, CRS_OFF_IRQ} && hrdata[3]);
	cover property (!bank_valid);
	cover property (rq == {1'b1, CRS_OFF_ACCESS});
endmodule
bind crs_core crs_core_asserts #(.RAM_BYTES(RAM_BYTES)) crs_core_asserts_i (.*);

// ===== bench/crs_mem_model.sv
`timescale 1ns/100ps
module crs_mem_model import crs_pkg::*; #(
	parameter int RAM_BYTES = 256
) (
	input  wire logic [15:0] bank_address,
	input  wire logic        bank_valid,
	output logic             bank_fits
);
	// eight byte banks must sit whole in ram above the io area
	assign bank_fits = !bank_valid || (bank_address >= CRS_DATA_BASE
		&& bank_address + 8 <= CRS_DATA_BASE + RAM_BYTES);
endmodule

// ===== bench/test_cpu_core_register_set.sv
`timescale 1ns/100ps
module test_cpu_core_register_set;
	import crs_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, r;
	logic [15:0] bank_address;
	logic        hreadyout, hresp, irq_accept, bank_valid, bank_fits;
	int          err_count = 0;
	int          checks = 0;
	int          cyc = 0;
	int          seed = 53;
	int          a, t, op, res, ps, e, n, z, c, h, v, bp;
	int          ad[5] = '{'h7f, 'h80, 'h7fff, 'h8000, 'hffff};
	always #5 hclk = ~hclk;
	crs_core crs_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_accept(irq_accept),
		.bank_address(bank_address), .bank_valid(bank_valid));
	crs_mem_model crs_mem_model_i (.bank_address(bank_address), .bank_valid(bank_valid),
		.bank_fits(bank_fits));
	// one single word transfer; the answer is awaited, not assumed
	task automatic xf(input bit w, input logic [7:0] ad8, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, ad8};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		xf(0, CRS_OFF_PC, 0);
		chk(r, 32'hfffd);
		xf(0, CRS_OFF_PS, 0);
		chk(r & 32'h70, 32'h30);
		for (int i = 0; i < 6; i++) begin
			a = $random(seed);
			xf(1, 8'(i * 4), a);
			xf(0, 8'(i * 4), 0);
			chk(r, a & 32'hffff);
		end
		$display("register test done");
		ps = 32'h30;
		h = 0;
		v = 0;
		xf(1, CRS_OFF_PS, ps);
		// only the low bytes of a and t feed the flag unit
		for (int i = 0; i < 40; i++) begin
			a = $random(seed);
			t = (i % 8 == 0) ? a : $random(seed);
			op = i % 4;
			xf(1, CRS_OFF_ACC, a);
			xf(1, CRS_OFF_TMP, t);
			xf(1, CRS_OFF_ALU, op);
			a &= 255;
			t &= 255;
			res = op == 0 ? a + t : op == 1 ? a - t : op == 2 ? a << 1 : a >> 1;
			n = (res >> 7) & 1;
			z = (res & 255) == 0;
			if (op < 2) begin
				c = op ? a < t : res > 255;
				h = op ? (a & 15) < (t & 15) : (a & 15) + (t & 15) > 15;
				v = ((a ^ (op ? ~t : t)) & 128) == 0 && ((a ^ res) & 128) != 0;
			end else c = op == 2 ? a >> 7 : a & 1;
			ps = (ps & 'hff70) | (h << 7) | (n << 3) | (z << 2) | (v << 1) | c;
			xf(0, CRS_OFF_PS, 0);
			chk(r & 32'h8f, ps & 32'h8f);
		end
		$display("flag test done");
		for (int i = 0; i < 40; i++) begin
			xf(1, CRS_OFF_PS, (ps & 'hff8f) | ((i & 1) << 6) | (((i >> 1) & 3) << 4));
			xf(1, CRS_OFF_IRQ, ((i < 32) << 2) | ((i >> 3) & 3));
			e = (i & 1) && i < 32 && ((i >> 3) & 3) < ((i >> 1) & 3) && ((i >> 1) & 3) != 3;
			xf(0, CRS_OFF_IRQ, 0);
			chk(irq_accept, e);
			chk(r[3], e);
		end
		$display("interrupt test done");
		for (int i = 0; i < 20; i++) begin
			bp = i < 17 ? i : $random(seed) & 255;
			xf(1, CRS_OFF_PS, (bp << 8) | 'h30);
			xf(0, CRS_OFF_BANK, 0);
			chk(r, {bp < 16, 16'(256 + bp * 8)});
			chk(bank_fits, 1);
		end
		foreach (ad[i]) begin
			xf(1, CRS_OFF_ACCESS, ad[i]);
			xf(0, CRS_OFF_ACCESS, 0);
			chk(r, ad[i] | (((ad[i] > 'h7f) + (ad[i] > 'h7fff)) << 16));
		end
		xf(1, 8'h2c, 32'hffffffff);
		xf(0, 8'h2c, 0);
		chk(r, 0);
		$display("bank and area test done");
		print_verdict();
	end
endmodule
